// *** dpr_pkg.sv ***
// Package: shared types and timing constants for the dual-port RAM port controller
`default_nettype none
package dpr_pkg;
    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W_64K  = 16;
    localparam int unsigned ADDR_W_128K = 17;
    localparam int unsigned DATA_W_X8   = 8;
    localparam int unsigned DATA_W_X9   = 9;
    localparam int unsigned SEM_COUNT   = 8;
    localparam int unsigned SEM_IDX_W   = 3;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned ACCESS_NS     = 25;
    localparam int unsigned ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAIT_W        = 4;

    // -------------------------------------------------------------------
    // Request and answer carriers
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        DPR_OP_READ  = 2'h0,
        DPR_OP_WRITE = 2'h1,
        DPR_OP_SEM   = 2'h2,
        DPR_OP_SEMRD = 2'h3
    } dpr_op_t;

    typedef struct packed {
        dpr_op_t     op;
        logic [16:0] addr;
        logic [8:0]  wdata;
    } dpr_req_t;

    typedef struct packed {
        logic [8:0] rdata;
        logic       busy_seen;
    } dpr_rsp_t;
endpackage : dpr_pkg
`default_nettype wire

// *** dpr_host.sv ***
// Module: controller that drives one port of the dual-port RAM through its pins
`default_nettype none
// Contract
// - Address is 16 or 17 bits, data 8 or 9 bits, by parameter.
// - This master drives its own port's enables, read/write and output enable.
// - One select pin sets master or slave for width expansion.
// - Ownership is a token: request, read back, and release when done.
module dpr_host #(
    parameter int unsigned ADDR_W   = dpr_pkg::ADDR_W_128K,
    parameter int unsigned DATA_W   = dpr_pkg::DATA_W_X9,
    parameter bit          IS_SLAVE = 1'b0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // User side
    input  wire logic             req_valid_i,
    output logic                  req_ready_o,
    input  wire dpr_pkg::dpr_req_t req_i,
    output logic                  rsp_valid_o,
    output dpr_pkg::dpr_rsp_t     rsp_o,
    output logic                  mailbox_irq_o,
    input  wire logic             slave_busy_i,
    // Device pins
    output logic [ADDR_W-1:0]     addr_o,
    input  wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0]     data_o,
    output logic                  data_oe_n_o,
    output logic                  port_select_low_active_n_o,
    output logic                  port_select_high_active_o,
    output logic                  rw_o,
    output logic                  out_en_n_o,
    output logic                  semaphore_access_select_n_o,
    output logic                  master_slave_o,
    input  wire logic             busy_n_i,
    output logic                  busy_n_o,
    output logic                  busy_oe_n_o,
    input  wire logic             int_n_i
);
    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {DPR_IDLE, DPR_ACCESS, DPR_DONE} dpr_state_t;

    dpr_state_t             state_q;
    dpr_pkg::dpr_req_t      req_q;
    logic [dpr_pkg::WAIT_W-1:0] wait_q;
    logic                   busy_seen_q;
    logic                   busy_now;
    logic                   take;
    logic                   access_end;

    localparam logic [dpr_pkg::WAIT_W-1:0] WAIT_INIT =
        dpr_pkg::WAIT_W'(dpr_pkg::ACCESS_CYC);

    function automatic logic is_write(input dpr_pkg::dpr_op_t op);
        return (op == dpr_pkg::DPR_OP_WRITE) || (op == dpr_pkg::DPR_OP_SEM);
    endfunction : is_write

    function automatic logic is_sem(input dpr_pkg::dpr_op_t op);
        return (op == dpr_pkg::DPR_OP_SEM) || (op == dpr_pkg::DPR_OP_SEMRD);
    endfunction : is_sem

    // -------------------------------------------------------------------
    // Master/slave and busy
    // -------------------------------------------------------------------
    assign master_slave_o = ~IS_SLAVE;
    assign busy_oe_n_o    = IS_SLAVE ? 1'b0 : 1'b1;
    assign busy_n_o       = ~slave_busy_i;
    assign busy_now       = IS_SLAVE ? slave_busy_i : ~busy_n_i;
    assign mailbox_irq_o  = ~int_n_i;
    assign req_ready_o    = (state_q == DPR_IDLE);

    // -------------------------------------------------------------------
    // Handshake decode
    // -------------------------------------------------------------------
    // A request is taken only from idle, so pins never move mid-access
    assign take       = (state_q == DPR_IDLE) && req_valid_i;
    // The access ends on the first quiet cycle once the wait has run out
    assign access_end = (state_q == DPR_ACCESS) && !busy_now && (wait_q <= 1);

    // -------------------------------------------------------------------
    // Access sequencer
    // -------------------------------------------------------------------
    // Sequence state: idle, one access, then one dead cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= DPR_IDLE;
        end else if (ce_i) begin
            case (state_q)
                DPR_IDLE: begin
                    if (take) begin
                        state_q <= DPR_ACCESS;
                    end
                end
                DPR_ACCESS: begin
                    if (access_end) begin
                        state_q <= DPR_DONE;
                    end
                end
                // The dead cycle keeps the port deselected between accesses
                DPR_DONE: state_q <= DPR_IDLE;
                default:  state_q <= DPR_IDLE;
            endcase
        end
    end

    // Request copy: only the operation is needed once the pins are set
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_q <= '0;
        end else if (ce_i && take) begin
            req_q <= req_i;
        end
    end

    // Access timer: busy reloads it, so a contended access gets its full
    // time once the far port has moved away
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= '0;
        end else if (ce_i) begin
            if (take || (state_q == DPR_ACCESS && busy_now)) begin
                wait_q <= WAIT_INIT;
            end else if (state_q == DPR_ACCESS && wait_q > 1) begin
                wait_q <= wait_q - 1'b1;
            end
        end
    end

    // Contention flag: cleared per request, set by any busy cycle during the access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_seen_q <= 1'b0;
        end else if (ce_i) begin
            if (take) begin
                busy_seen_q <= 1'b0;
            end else if (state_q == DPR_ACCESS && busy_now) begin
                busy_seen_q <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Answer capture
    // -------------------------------------------------------------------
    // Answer strobe: one cycle, on the edge that ends the access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
        end else if (ce_i) begin
            rsp_valid_o <= access_end;
        end
    end

    // Answer word: read data is taken while the port still drives it,
    // then holds until the next answer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else if (ce_i && access_end) begin
            rsp_o.rdata     <= is_write(req_q.op) ? '0 : 9'(data_i);
            rsp_o.busy_seen <= busy_seen_q;
        end
    end

    // -------------------------------------------------------------------
    // Pin drive
    // -------------------------------------------------------------------
    // Address and write data move only when a request is taken, so they
    // stand unchanged for the whole access, busy stretch included
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_o <= '0;
            data_o <= '0;
        end else if (ce_i && take) begin
            // Semaphore index sits in the low address bits
            addr_o <= is_sem(req_i.op)
                ? ADDR_W'(req_i.addr[dpr_pkg::SEM_IDX_W-1:0])
                : req_i.addr[ADDR_W-1:0];
            data_o <= req_i.wdata[DATA_W-1:0];
        end
    end

    // Strobes: memory and semaphore selects are never on together, and
    // everything returns to idle on the edge that ends the access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_oe_n_o                 <= 1'b1;
            port_select_low_active_n_o  <= 1'b1;
            port_select_high_active_o   <= 1'b0;
            rw_o                        <= 1'b1;
            out_en_n_o                  <= 1'b1;
            semaphore_access_select_n_o <= 1'b1;
        end else if (ce_i) begin
            if (take) begin
                data_oe_n_o                 <= ~is_write(req_i.op);
                rw_o                        <= ~is_write(req_i.op);
                out_en_n_o                  <= is_write(req_i.op);
                semaphore_access_select_n_o <= ~is_sem(req_i.op);
                port_select_low_active_n_o  <= is_sem(req_i.op);
                port_select_high_active_o   <= ~is_sem(req_i.op);
            end else if (access_end) begin
                // Deselect after the access so the port powers down
                data_oe_n_o                 <= 1'b1;
                port_select_low_active_n_o  <= 1'b1;
                port_select_high_active_o   <= 1'b0;
                rw_o                        <= 1'b1;
                out_en_n_o                  <= 1'b1;
                semaphore_access_select_n_o <= 1'b1;
            end
        end
    end
endmodule : dpr_host
`default_nettype wire

// *** dpr_checker.sv ***
// Checker: port assertions for the dual-port RAM controller
`default_nettype none
module dpr_checker #(
    parameter int unsigned ADDR_W   = 17,
    parameter bit          IS_SLAVE = 1'b0
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              ce_i,
    input wire logic              req_valid_i,
    input wire logic              req_ready_o,
    input wire logic              rsp_valid_o,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic              port_select_low_active_n_o,
    input wire logic              master_slave_o,
    input wire logic              busy_oe_n_o,
    input wire logic              mailbox_irq_o,
    input wire logic              int_n_i
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken; ce_i && req_valid_i && req_ready_o; endsequence
    sequence s_sel2; !port_select_low_active_n_o ##1 !port_select_low_active_n_o; endsequence
    property p_answer; s_taken |-> ##[2:12] rsp_valid_o; endproperty
    property p_done; rsp_valid_o && ce_i |-> !req_ready_o ##1 req_ready_o; endproperty
    property p_idle; req_ready_o |-> port_select_low_active_n_o; endproperty
    property p_hold; s_sel2 |-> $stable(addr_o); endproperty
    property p_ms; master_slave_o == !IS_SLAVE; endproperty
    property p_bdir; busy_oe_n_o == !IS_SLAVE; endproperty
    property p_irq; mailbox_irq_o == !int_n_i; endproperty
    a_answer: assert property (p_answer) else $error("no answer in time");
    a_done: assert property (p_done) else $error("ready after answer");
    a_idle: assert property (p_idle) else $error("selected while idle");
    a_hold: assert property (p_hold) else $error("address moved");
    a_ms: assert property (p_ms) else $error("mode pin wrong");
    a_bdir: assert property (p_bdir) else $error("busy pin direction");
    a_irq: assert property (p_irq) else $error("mailbox flag wrong");
endmodule : dpr_checker
bind dpr_host dpr_checker #(.ADDR_W(ADDR_W), .IS_SLAVE(IS_SLAVE)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .addr_o(addr_o),
    .port_select_low_active_n_o(port_select_low_active_n_o), .master_slave_o(master_slave_o),
    .busy_oe_n_o(busy_oe_n_o), .mailbox_irq_o(mailbox_irq_o), .int_n_i(int_n_i));
`default_nettype wire

// *** dpr_dev_model.sv ***
// Model: behavioural RAM port with busy, semaphores and mailbox
`default_nettype none
module dpr_dev_model (
    input wire logic        clk_i,
    input wire logic [16:0] a_i,
    input wire logic [8:0]  w_i,
    input wire logic        sel_n_i,
    input wire logic        sel_i,
    input wire logic        rw_i,
    input wire logic        oe_n_i,
    input wire logic        sem_n_i,
    input wire logic        far_act_i,
    input wire logic [16:0] far_a_i,
    input wire logic [7:0]  far_hold_i,
    input wire logic        far_irq_i,
    output logic [8:0]      r_o,
    output logic            busy_n_o,
    output logic            int_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] mem [0:131071];
    logic [7:0] own_q = 8'h00;
    logic [8:0] last_q = 9'h000;
    logic       on;
    assign on = !sel_n_i && sel_i;
    assign busy_n_o = !(on && far_act_i && a_i == far_a_i);
    assign int_n_o = !far_irq_i;
    always_comb begin
        if (!sem_n_i && rw_i && !oe_n_i) r_o = {9{!own_q[a_i[2:0]]}};
        else if (on && rw_i && !oe_n_i) r_o = mem[a_i];
        else r_o = ~last_q;
    end
    always @(posedge clk_i) begin
        if (on && !rw_i) mem[a_i] <= w_i;
        if (!sem_n_i && !rw_i) own_q[a_i[2:0]] <= !w_i[0] && !far_hold_i[a_i[2:0]];
        last_q <= r_o;
    end
endmodule : dpr_dev_model
`default_nettype wire

// *** dpr_host_test.sv ***
// Testbench: self-checking bench for the dual-port RAM controller
`default_nettype none
module dpr_host_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, rst_i = 1, req_valid_i = 0, far_act = 0, far_irq = 0;
    logic ce = 1, sbusy = 0;
    dpr_pkg::dpr_req_t req_i = '0;
    dpr_pkg::dpr_rsp_t rsp_o;
    logic [16:0] addr, far_a = '0;
    logic [8:0] d_out, d_dev, d_in;
    logic [7:0] far_hold = '0;
    logic rdy, rsp_v, irq, d_oe_n, sel_n, sel, rw, oe_n, sem_n, ms, b_out, b_oe_n, b_dev, int_n;
    int errors = 0, checked = 0;
    assign d_in = d_oe_n ? d_dev : d_out;
    initial forever #12.5 clk_i = !clk_i;
    dpr_host dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .req_valid_i(req_valid_i),
        .req_ready_o(rdy), .req_i(req_i), .rsp_valid_o(rsp_v), .rsp_o(rsp_o),
        .mailbox_irq_o(irq), .slave_busy_i(sbusy), .addr_o(addr), .data_i(d_in),
        .data_o(d_out), .data_oe_n_o(d_oe_n), .port_select_low_active_n_o(sel_n),
        .port_select_high_active_o(sel), .rw_o(rw), .out_en_n_o(oe_n),
        .semaphore_access_select_n_o(sem_n), .master_slave_o(ms),
        .busy_n_i(b_oe_n ? b_dev : b_out), .busy_n_o(b_out), .busy_oe_n_o(b_oe_n), .int_n_i(int_n));
    dpr_dev_model u_dev (.clk_i(clk_i), .a_i(addr), .w_i(d_in), .sel_n_i(sel_n), .sel_i(sel),
        .rw_i(rw), .oe_n_i(oe_n), .sem_n_i(sem_n), .far_act_i(far_act), .far_a_i(far_a),
        .far_hold_i(far_hold), .far_irq_i(far_irq), .r_o(d_dev), .busy_n_o(b_dev), .int_n_o(int_n));
    task automatic end_sim();
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic [1:0] op, input logic [16:0] a, input logic [8:0] w,
                        input logic [8:0] er, input logic eb);
        int n = 0;
        while (rdy !== 1'b1 && n < 50) begin @(posedge clk_i); #2; n++; end
        req_i = {dpr_pkg::dpr_op_t'(op), a, w};
        req_valid_i = 1;
        @(posedge clk_i);
        #2 req_valid_i = 0;
        while (rsp_v !== 1'b1 && n < 50) begin @(posedge clk_i); #2; n++; end
        chk(rsp_v, 1'b1);
        chk(rsp_o.busy_seen, eb);
        if (op[1] == op[0]) chk(rsp_o.rdata, er);
    endtask : xfer
    task automatic t_rw();
        xfer(2'h1, 17'h1ffff, 9'h1a5, 0, 0);
        xfer(2'h1, 17'h00000, 9'h05a, 0, 0);
        xfer(2'h0, 17'h1ffff, 0, 9'h1a5, 0);
        xfer(2'h0, 17'h00000, 0, 9'h05a, 0);
    endtask : t_rw
    task automatic t_busy();
        far_a = 17'h1ffff;
        far_act = 1;
        fork
            xfer(2'h0, 17'h1ffff, 0, 9'h1a5, 1);
            begin repeat (3) @(posedge clk_i); #2 far_act = 0; end
        join
    endtask : t_busy
    task automatic t_sem();
        far_hold = 8'h20;
        xfer(2'h2, 17'h00003, 9'h000, 0, 0);
        xfer(2'h3, 17'h00003, 0, 9'h000, 0);
        xfer(2'h2, 17'h00005, 9'h000, 0, 0);
        xfer(2'h3, 17'h00005, 0, 9'h1ff, 0);
        xfer(2'h2, 17'h00003, 9'h001, 0, 0);
        xfer(2'h3, 17'h00003, 0, 9'h1ff, 0);
    endtask : t_sem
    task automatic t_pins();
        chk({sel_n, oe_n, rw}, 3'h7);
        chk({ms, b_oe_n}, 2'h3);
        chk(b_out, 1'b1);
        sbusy = 1;
        far_irq = 1;
        @(posedge clk_i);
        #2 chk(irq, 1'b1);
        chk(b_out, 1'b0);
        sbusy = 0;
        far_irq = 0;
    endtask : t_pins
    task automatic t_ce();
        int n = 0;
        @(posedge clk_i);
        #2 ce = 0;
        req_i = {dpr_pkg::DPR_OP_READ, 17'h00000, 9'h000};
        req_valid_i = 1;
        repeat (3) @(posedge clk_i);
        #2 chk({rdy, sel_n, rsp_v}, 3'h6);
        ce = 1;
        @(posedge clk_i);
        #2 req_valid_i = 0;
        while (rsp_v !== 1'b1 && n < 50) begin @(posedge clk_i); #2; n++; end
        chk(rsp_v, 1'b1);
        chk(rsp_o.rdata, 9'h05a);
    endtask : t_ce
    initial begin
        repeat (16) @(posedge clk_i);
        #2 rst_i = 0;
        t_pins();
        t_rw();
        t_busy();
        t_sem();
        t_ce();
        end_sim();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        end_sim();
    end
endmodule : dpr_host_test
`default_nettype wire
